// >>> preset_pkg.sv
// constants, types and register map of the single-register preset handler
package preset_pkg;

  // ---------------------------------------------------------------
  // sizes and codes
  // ---------------------------------------------------------------
  localparam int NUM_SENSORS = 8;
  localparam logic [15:0] WRITE_KEY = 16'h4000;
  localparam logic [15:0] CODE_ENGAGE = 16'h00ff;
  localparam logic [15:0] CODE_STOP = 16'h0000;
  localparam logic [15:0] PARAM_RESET = 16'h0000;
  localparam logic [7:0] EXC_ILLEGAL_ADDR = 8'h02;
  localparam logic [7:0] EXC_BAD_ROLE = 8'h03;
  localparam logic [7:0] EXC_NO_KEY = 8'h08;

  // ---------------------------------------------------------------
  // sensor regions: internal address = base + span * region + offset
  // ---------------------------------------------------------------
  localparam logic [15:0] REGION_BASE = 16'h07d0;
  localparam logic [15:0] REGION_SPAN = 16'h0064;
  localparam logic [3:0] REGION_ALL = 4'h0;
  localparam logic [3:0] REGION_UNIT = 4'h9;
  localparam logic [6:0] OFS_ALARM_LOW = 7'h03;
  localparam logic [6:0] OFS_ALARM_MID = 7'h04;
  localparam logic [6:0] OFS_ALARM_HIGH = 7'h05;
  localparam logic [6:0] OFS_CALIBRATION = 7'h06;
  localparam logic [6:0] OFS_ZONE = 7'h0a;
  localparam logic [6:0] OFS_SELF_TEST = 7'h27;

  // ---------------------------------------------------------------
  // unit registers (region nine)
  // ---------------------------------------------------------------
  localparam logic [15:0] CLOCK_MONTH_PENDING = 16'h0b5f;
  localparam logic [15:0] CLOCK_DAY_PENDING = 16'h0b60;
  localparam logic [15:0] CLOCK_YEAR_PENDING = 16'h0b61;
  localparam logic [15:0] CLOCK_HOURS_PENDING = 16'h0b62;
  localparam logic [15:0] CLOCK_MINUTES_PENDING = 16'h0b63;
  localparam logic [15:0] CLOCK_SECONDS_PENDING = 16'h0b64;
  localparam logic [15:0] CLOCK_COMMIT = 16'h0b65;
  localparam logic [15:0] DIAG_FORCE_OUTPUTS = 16'h0b66;
  localparam logic [15:0] LISTEN_ONLY_ENGAGE = 16'h0b67;
  localparam logic [15:0] LISTEN_ONLY_RESTORE = 16'h0b68;

  // diagnostic force field: bits 0..3 relay coils, bit 4 lamp swap
  localparam int DIAG_FORCE_LSB = 0;
  localparam int DIAG_FORCE_WIDTH = 5;
  localparam logic [4:0] DIAG_FORCE_RESET = 5'h00;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam longint unsigned CLK_HZ = 64'd100_000_000;
  localparam longint unsigned FORCE_HOLD_S = 64'd30;
  localparam longint unsigned FORCE_HOLD_CYCLES = FORCE_HOLD_S * CLK_HZ;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ROLE_SINGLE = 2'b00,
    ROLE_UNIQUE = 2'b01,
    ROLE_IDENTICAL = 2'b10
  } sensor_role_type;

  typedef enum logic {
    MODE_NORMAL = 1'b0,
    MODE_LISTEN = 1'b1
  } link_mode_type;

  typedef enum logic {
    RESP_ECHO = 1'b0,
    RESP_EXCEPTION = 1'b1
  } resp_kind_type;

  typedef struct packed {
    logic broadcast;
    logic [15:0] reg_addr;
    logic [15:0] value;
  } preset_req_type;

  typedef struct packed {
    resp_kind_type kind;
    logic [7:0] exc_code;
    logic [15:0] reg_addr;
    logic [15:0] value;
  } preset_resp_type;

  typedef struct packed {
    logic [15:0] alarm_low;
    logic [15:0] alarm_mid;
    logic [15:0] alarm_high;
    logic [15:0] calibration;
    logic [15:0] zone;
    logic [15:0] self_test;
  } sensor_params_type;

  typedef struct packed {
    logic [15:0] month;
    logic [15:0] day;
    logic [15:0] year;
    logic [15:0] hours;
    logic [15:0] minutes;
    logic [15:0] seconds;
  } unit_clock_type;

endpackage

// >>> sensor_region.sv
// per-sensor preset registers: set points, calibration, zone, self test
module sensor_region
  import preset_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  input wire logic wr_en_in,
  input wire logic [6:0] ofs_in,
  input wire logic [15:0] data_in,
  output sensor_params_type params_out,
  output logic self_test_run_out
);

  sensor_params_type params_q, params_d;
  logic run_q, run_d;

  // ---------------------------------------------------------------
  // next values
  // ---------------------------------------------------------------
  // offset already qualified by the caller; unknown offsets change nothing
  always_comb begin
    params_d = params_q;
    run_d = run_q;
    if (wr_en_in) begin
      case (ofs_in)
        OFS_ALARM_LOW: params_d.alarm_low = data_in;
        OFS_ALARM_MID: params_d.alarm_mid = data_in;
        OFS_ALARM_HIGH: params_d.alarm_high = data_in;
        OFS_CALIBRATION: params_d.calibration = data_in;
        OFS_ZONE: params_d.zone = data_in;
        OFS_SELF_TEST: begin
          params_d.self_test = data_in;
          // other codes are stored but leave the test as it is
          if (data_in == CODE_ENGAGE) run_d = 1'b1;
          else if (data_in == CODE_STOP) run_d = 1'b0;
        end
        default: params_d = params_q;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      params_q <= '{PARAM_RESET, PARAM_RESET, PARAM_RESET,
                    PARAM_RESET, PARAM_RESET, PARAM_RESET};
      run_q <= 1'b0;
    end else if (ce_in) begin
      params_q <= params_d;
      run_q <= run_d;
    end
  end

  assign params_out = params_q;
  assign self_test_run_out = run_q;

endmodule // sensor_region

// >>> force_hold_timer.sv
// holds diagnostic forces for a fixed time after each write
module force_hold_timer
  import preset_pkg::*;
#(
  parameter logic [31:0] HOLD_CYCLES = 32'(FORCE_HOLD_CYCLES)
) (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  input wire logic load_in,
  input wire logic [4:0] force_in,
  output logic [4:0] force_out
);

  logic [31:0] count_q, count_d;
  logic [4:0] force_q, force_d;

  // ---------------------------------------------------------------
  // next values
  // ---------------------------------------------------------------
  // a rewrite restarts the window, so a polling master can hold forever
  always_comb begin
    count_d = count_q;
    force_d = force_q;
    if (load_in) begin
      force_d = force_in;
      count_d = HOLD_CYCLES;
    end else if (count_q == 32'h0000_0001) begin
      count_d = 32'h0000_0000;
      force_d = DIAG_FORCE_RESET;
    end else if (count_q != 32'h0000_0000) begin
      count_d = count_q - 32'h0000_0001;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      count_q <= 32'h0000_0000;
      force_q <= DIAG_FORCE_RESET;
    end else if (ce_in) begin
      count_q <= count_d;
      force_q <= force_d;
    end
  end

  assign force_out = force_q;

endmodule // force_hold_timer

// >>> preset_handler.sv
// single-register preset command interpreter for a multi-sensor unit
//
// Function
// - broadcasts refused except listen-only pair
// - region zero write goes to every attached sensor
// - one 16-bit value, no counts
// - set points and calibration at alarm_low_setpoint..calibration_value
// - self test: start code runs, zero stops
// - region-zero zone/self test need multi-sensor role
// - six pending clock registers held
// - commit set code loads clock; zero clears
// - force bits drive coils and lamp swap
// - force releases after thirty seconds unless rewritten
// - listen-only engage silences all but restore
// - restore resumes responses
// - success answered by exact echo after update
// - invalid address gives exception code 2
// - missing key gives exception 8, no change
// - regions at multiples of hundred; zero, nine special
module preset_handler
  import preset_pkg::*;
#(
  parameter logic [31:0] FORCE_CYCLES = 32'(FORCE_HOLD_CYCLES)
) (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  input wire logic req_valid_in,
  input preset_req_type req_in,
  input wire logic [3:0] sensors_attached_in,
  input sensor_role_type sensor_role_in,
  output logic resp_valid_out,
  output preset_resp_type resp_out,
  output sensor_params_type [NUM_SENSORS-1:0] sensor_params_out,
  output logic [NUM_SENSORS-1:0] self_test_run_out,
  output unit_clock_type clock_pending_out,
  output logic clock_commit_pending_out,
  output logic clock_load_out,
  output logic [3:0] relay_force_out,
  output logic led_swap_out,
  output logic listen_only_out
);

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  logic [3:0] region;
  logic [6:0] ofs;
  logic in_map;
  logic sensor_ofs_ok;
  logic zone_or_test;
  logic unit_ok;
  logic region_ok;
  logic [15:0] rel_addr;

  // split the address into region and offset by range compare;
  // cheaper than a divider and regions are few
  always_comb begin
    region = REGION_ALL;
    ofs = 7'h00;
    in_map = 1'b0;
    rel_addr = 16'h0000;
    for (int r = 0; r < 10; r++) begin
      rel_addr = req_in.reg_addr - REGION_BASE - 16'(r) * REGION_SPAN;
      if (req_in.reg_addr >= REGION_BASE + 16'(r) * REGION_SPAN &&
          rel_addr < REGION_SPAN) begin
        region = 4'(r);
        ofs = rel_addr[6:0];
        in_map = 1'b1;
      end
    end
  end

  // which offsets and unit registers take a preset
  always_comb begin
    sensor_ofs_ok = (ofs == OFS_ALARM_LOW) || (ofs == OFS_ALARM_MID) ||
                    (ofs == OFS_ALARM_HIGH) || (ofs == OFS_CALIBRATION) ||
                    (ofs == OFS_ZONE) || (ofs == OFS_SELF_TEST);
    zone_or_test = (ofs == OFS_ZONE) || (ofs == OFS_SELF_TEST);
    unit_ok = (req_in.reg_addr >= CLOCK_MONTH_PENDING) &&
              (req_in.reg_addr <= LISTEN_ONLY_RESTORE);
    if (!in_map) begin
      region_ok = 1'b0;
    end else if (region == REGION_UNIT) begin
      region_ok = unit_ok;
    end else if (region == REGION_ALL) begin
      region_ok = sensor_ofs_ok && (sensors_attached_in != 4'h0);
    end else if (sensor_role_in == ROLE_SINGLE) begin
      // single role exposes only the first sensor region
      region_ok = sensor_ofs_ok && (region == 4'h1);
    end else begin
      region_ok = sensor_ofs_ok && (region <= sensors_attached_in);
    end
  end

  // ---------------------------------------------------------------
  // command checks
  // ---------------------------------------------------------------
  link_mode_type mode_q, mode_d;
  logic is_listen_pair;
  logic is_restore;
  logic take;
  logic role_bad;
  logic key_ok;
  logic do_write;
  logic [15:0] stripped;
  logic [7:0] exc_code;
  logic exc;

  always_comb begin
    is_restore = (req_in.reg_addr == LISTEN_ONLY_RESTORE);
    is_listen_pair = is_restore ||
                     (req_in.reg_addr == LISTEN_ONLY_ENGAGE);
    // value must carry the key; anything below it is refused
    key_ok = (req_in.value >= WRITE_KEY);
    stripped = req_in.value - WRITE_KEY;
    role_bad = (region == REGION_ALL) && zone_or_test &&
               ((sensor_role_in == ROLE_SINGLE) ||
                (sensors_attached_in < 4'h2));
    // broadcast and listen-only both filter before any decode
    take = req_valid_in &&
           (!req_in.broadcast || is_listen_pair) &&
           ((mode_q == MODE_NORMAL) || is_restore);
    if (!region_ok) begin
      exc = 1'b1;
      exc_code = EXC_ILLEGAL_ADDR;
    end else if (role_bad) begin
      exc = 1'b1;
      exc_code = EXC_BAD_ROLE;
    end else if (!key_ok) begin
      exc = 1'b1;
      exc_code = EXC_NO_KEY;
    end else begin
      exc = 1'b0;
      exc_code = 8'h00;
    end
    do_write = take && !exc;
  end

  // ---------------------------------------------------------------
  // sensor regions
  // ---------------------------------------------------------------
  logic [NUM_SENSORS-1:0] sensor_wr;

  // region zero fans out to every attached sensor
  always_comb begin
    for (int s = 0; s < NUM_SENSORS; s++) begin
      sensor_wr[s] = do_write &&
                     (4'(s + 1) <= sensors_attached_in) &&
                     ((region == REGION_ALL) ||
                      (region == 4'(s + 1)));
    end
  end

  generate
    for (genvar g = 0; g < NUM_SENSORS; g++) begin : gen_sensor
      sensor_region u_region (
        .core_clk_in(core_clk_in),
        .reset_in(reset_in),
        .ce_in(ce_in),
        .wr_en_in(sensor_wr[g]),
        .ofs_in(ofs),
        .data_in(stripped),
        .params_out(sensor_params_out[g]),
        .self_test_run_out(self_test_run_out[g])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // unit registers and mode
  // ---------------------------------------------------------------
  unit_clock_type clock_q, clock_d;
  logic commit_q, commit_d;
  logic load_q, load_d;
  logic unit_wr;
  logic force_load;

  always_comb begin
    clock_d = clock_q;
    commit_d = commit_q;
    load_d = 1'b0;
    mode_d = mode_q;
    unit_wr = do_write && (region == REGION_UNIT);
    force_load = unit_wr && (req_in.reg_addr == DIAG_FORCE_OUTPUTS);
    if (unit_wr) begin
      if (req_in.reg_addr == CLOCK_MONTH_PENDING) begin
        clock_d.month = stripped;
      end else if (req_in.reg_addr == CLOCK_DAY_PENDING) begin
        clock_d.day = stripped;
      end else if (req_in.reg_addr == CLOCK_YEAR_PENDING) begin
        clock_d.year = stripped;
      end else if (req_in.reg_addr == CLOCK_HOURS_PENDING) begin
        clock_d.hours = stripped;
      end else if (req_in.reg_addr == CLOCK_MINUTES_PENDING) begin
        clock_d.minutes = stripped;
      end else if (req_in.reg_addr == CLOCK_SECONDS_PENDING) begin
        clock_d.seconds = stripped;
      end else if (req_in.reg_addr == CLOCK_COMMIT) begin
        if (stripped == CODE_ENGAGE) begin
          commit_d = 1'b1;
          load_d = 1'b1;
        end else if (stripped == CODE_STOP) begin
          commit_d = 1'b0;
        end
      end else if (req_in.reg_addr == LISTEN_ONLY_ENGAGE) begin
        if (stripped == CODE_ENGAGE) mode_d = MODE_LISTEN;
      end else if (req_in.reg_addr == LISTEN_ONLY_RESTORE) begin
        if (stripped == CODE_ENGAGE) mode_d = MODE_NORMAL;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      clock_q <= '{PARAM_RESET, PARAM_RESET, PARAM_RESET,
                   PARAM_RESET, PARAM_RESET, PARAM_RESET};
      commit_q <= 1'b0;
      load_q <= 1'b0;
      mode_q <= MODE_NORMAL;
    end else if (ce_in) begin
      clock_q <= clock_d;
      commit_q <= commit_d;
      load_q <= load_d;
      mode_q <= mode_d;
    end
  end

  // ---------------------------------------------------------------
  // diagnostic force hold
  // ---------------------------------------------------------------
  logic [4:0] force_now;

  force_hold_timer #(
    .HOLD_CYCLES(FORCE_CYCLES)
  ) u_force (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .ce_in(ce_in),
    .load_in(force_load),
    .force_in(stripped[DIAG_FORCE_LSB +: DIAG_FORCE_WIDTH]),
    .force_out(force_now)
  );

  // ---------------------------------------------------------------
  // response
  // ---------------------------------------------------------------
  preset_resp_type resp_q, resp_d;
  logic resp_valid_q, resp_valid_d;

  // broadcasts never answer; the engage write itself goes silent,
  // the restore write answers again
  always_comb begin
    resp_d = resp_q;
    resp_valid_d = 1'b0;
    if (take && !req_in.broadcast &&
        !(do_write && (mode_d == MODE_LISTEN))) begin
      resp_valid_d = 1'b1;
      resp_d.reg_addr = req_in.reg_addr;
      resp_d.value = req_in.value;
      resp_d.kind = exc ? RESP_EXCEPTION : RESP_ECHO;
      resp_d.exc_code = exc_code;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      resp_q <= '{RESP_ECHO, 8'h00, 16'h0000, 16'h0000};
      resp_valid_q <= 1'b0;
    end else if (ce_in) begin
      resp_q <= resp_d;
      resp_valid_q <= resp_valid_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign resp_valid_out = resp_valid_q;
  assign resp_out = resp_q;
  assign clock_pending_out = clock_q;
  assign clock_commit_pending_out = commit_q;
  assign clock_load_out = load_q;
  assign relay_force_out = force_now[3:0];
  assign led_swap_out = force_now[4];
  assign listen_only_out = (mode_q == MODE_LISTEN);

endmodule // preset_handler

// >>> preset_checker.sv
// concurrent checks on the preset handler ports
module preset_checker
  import preset_pkg::*;
#(
  parameter logic [31:0] FORCE_CYCLES = 32'd20
) (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  input wire logic req_valid_in,
  input preset_req_type req_in,
  input wire logic resp_valid_out,
  input preset_resp_type resp_out,
  input wire logic clock_commit_pending_out,
  input wire logic clock_load_out,
  input wire logic [3:0] relay_force_out,
  input wire logic led_swap_out,
  input wire logic listen_only_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // helper terms
  // ---------------------------------------------------------------
  logic take, ucast, wr_ok, is_force;
  logic [31:0] idle_q, idle_d;
  assign take = ce_in && req_valid_in && !listen_only_out;
  assign ucast = take && !req_in.broadcast;
  assign wr_ok = ucast && (req_in.value >= WRITE_KEY);
  assign is_force = req_in.reg_addr == DIAG_FORCE_OUTPUTS;
  // cycles since the last accepted force write, saturating
  always_comb begin
    idle_d = idle_q;
    if (wr_ok && is_force) idle_d = '0;
    else if (ce_in && idle_q != '1) idle_d = idle_q + 32'd1;
  end
  always_ff @(posedge core_clk_in) begin
    if (reset_in) idle_q <= '0;
    else idle_q <= idle_d;
  end
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (reset_in);
  a_answer_cause: assert property (resp_valid_out |->
    $past(ce_in && req_valid_in)) else $error("answer with no request");
  a_bcast_silent: assert property (ce_in && req_valid_in &&
    req_in.broadcast |=> !resp_valid_out) else $error("broadcast answered");
  a_listen_quiet: assert property (ce_in && req_valid_in &&
    listen_only_out && req_in.reg_addr != LISTEN_ONLY_RESTORE
    |=> !resp_valid_out) else $error("answer while listening");
  a_echo_exact: assert property (resp_valid_out &&
    resp_out.kind == RESP_ECHO |-> resp_out.reg_addr == $past(req_in.reg_addr)
    && resp_out.value == $past(req_in.value)) else $error("echo differs");
  a_key_refused: assert property (ucast && is_force &&
    req_in.value < WRITE_KEY |=> resp_valid_out && resp_out.kind ==
    RESP_EXCEPTION && resp_out.exc_code == EXC_NO_KEY)
    else $error("missing key not refused");
  a_bad_address: assert property (ucast &&
    req_in.reg_addr == 16'h0b5e |=> resp_valid_out && resp_out.kind ==
    RESP_EXCEPTION && resp_out.exc_code == EXC_ILLEGAL_ADDR)
    else $error("bad address not refused");
  a_commit_load: assert property (wr_ok &&
    req_in.reg_addr == CLOCK_COMMIT && req_in.value == 16'h40ff
    |=> clock_load_out && clock_commit_pending_out) else $error("no load");
  a_load_cause: assert property (clock_load_out |->
    $past(wr_ok && req_in.reg_addr == CLOCK_COMMIT && req_in.value ==
    16'h40ff)) else $error("clock load without commit");
  a_engage_enter: assert property (take &&
    req_in.reg_addr == LISTEN_ONLY_ENGAGE && req_in.value == 16'h40ff
    |=> listen_only_out && !resp_valid_out) else $error("engage missed");
  a_force_load: assert property (wr_ok && is_force |=>
    relay_force_out == $past(req_in.value[3:0]) &&
    led_swap_out == $past(req_in.value[4])) else $error("force not loaded");
  a_force_release: assert property (idle_q > FORCE_CYCLES + 1 |->
    relay_force_out == 4'h0 && !led_swap_out) else $error("force stuck");
  // main scenarios reached
  c_commit: cover property (wr_ok && req_in.reg_addr == CLOCK_COMMIT);
  c_listen: cover property (listen_only_out && req_valid_in);
  c_release: cover property ((|relay_force_out) ##1 !(|relay_force_out));
endmodule // preset_checker

bind preset_handler preset_checker #(.FORCE_CYCLES(FORCE_CYCLES))
  i_preset_checker (.core_clk_in, .reset_in, .ce_in, .req_valid_in,
  .req_in, .resp_valid_out, .resp_out, .clock_commit_pending_out,
  .clock_load_out, .relay_force_out, .led_swap_out, .listen_only_out);

// >>> modbus_master.sv
// serial link master model issuing single-register presets
module modbus_master
  import preset_pkg::*;
(
  input wire logic core_clk_in,
  output logic req_valid_out,
  output preset_req_type req_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus at time zero
  initial begin
    req_valid_out = 1'b0;
    req_out = '0;
  end
  // ---------------------------------------------------------------
  // one preset frame: key added unless a refusal is wanted
  // ---------------------------------------------------------------
  task automatic preset(input logic bcast, input logic [15:0] addr,
      input logic [15:0] val, input logic keyed);
    @(posedge core_clk_in);
    #1;
    req_out.broadcast = bcast;
    req_out.reg_addr = addr;
    req_out.value = keyed ? val + WRITE_KEY : val;
    req_valid_out = 1'b1;
    @(posedge core_clk_in);
    #1;
    req_valid_out = 1'b0;
    // released bus shows the inverse
    req_out.value = ~req_out.value;
  endtask
endmodule // modbus_master

// >>> tb.sv
// self-checking bench for the single-register preset handler
module tb;
  import preset_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] HOLD = 32'd20;
  logic core_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic req_valid;
  preset_req_type req;
  logic [3:0] attached = 4'h8;
  sensor_role_type role = ROLE_UNIQUE;
  logic resp_valid, clk_pend, clk_load, led_swap, listen;
  preset_resp_type resp;
  sensor_params_type [NUM_SENSORS-1:0] params;
  logic [NUM_SENSORS-1:0] st_run;
  unit_clock_type clk_pending;
  logic [3:0] relay;
  int bad_count = 0, compares = 0;
  always #5 core_clk_in = ~core_clk_in;
  modbus_master i_modbus_master (.core_clk_in(core_clk_in),
    .req_valid_out(req_valid), .req_out(req));
  logic ce = 1'b1;
  preset_handler #(.FORCE_CYCLES(HOLD)) i_preset_handler (
    .core_clk_in(core_clk_in), .reset_in(reset_in), .ce_in(ce),
    .req_valid_in(req_valid), .req_in(req), .sensors_attached_in(attached),
    .sensor_role_in(role), .resp_valid_out(resp_valid), .resp_out(resp),
    .sensor_params_out(params), .self_test_run_out(st_run),
    .clock_pending_out(clk_pending), .clock_commit_pending_out(clk_pend),
    .clock_load_out(clk_load), .relay_force_out(relay),
    .led_swap_out(led_swap), .listen_only_out(listen));
  // ---------------------------------------------------------------
  // shared helpers
  // ---------------------------------------------------------------
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  function automatic logic [15:0] s_addr(int r, logic [6:0] ofs);
    return 16'(REGION_BASE + REGION_SPAN * r + ofs);
  endfunction
  function automatic logic [15:0] field(int s, logic [6:0] ofs);
    case (ofs)
      OFS_ALARM_LOW: return params[s].alarm_low;
      OFS_ALARM_MID: return params[s].alarm_mid;
      OFS_ALARM_HIGH: return params[s].alarm_high;
      default: return params[s].calibration;
    endcase
  endfunction
  task automatic echo(input logic [15:0] addr, input logic [15:0] val);
    i_modbus_master.preset(1'b0, addr, val, 1'b1);
    check({resp_valid, resp.kind, resp.reg_addr, resp.value},
      {1'b1, RESP_ECHO, addr, val + WRITE_KEY});
  endtask
  task automatic refuse(input logic [15:0] addr, input logic [15:0] val,
      input logic keyed, input logic [7:0] code);
    i_modbus_master.preset(1'b0, addr, val, keyed);
    check({resp_valid, resp.kind, resp.exc_code},
      {1'b1, RESP_EXCEPTION, code});
  endtask
  task automatic quiet(input logic bc, input logic [15:0] addr,
      input logic [15:0] val);
    i_modbus_master.preset(bc, addr, val, 1'b1);
    check(resp_valid, 1'b0);
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_sensor_regs();
    logic [6:0] ofs[4] = '{OFS_ALARM_LOW, OFS_ALARM_MID, OFS_ALARM_HIGH,
      OFS_CALIBRATION};
    check({listen, relay, led_swap, clk_pend, st_run}, '0);
    for (int i = 0; i < 4; i++) begin
      echo(s_addr(2, ofs[i]), 16'h0100 + ofs[i]);
      check(field(1, ofs[i]), 16'h0100 + ofs[i]);
      check(field(0, ofs[i]), PARAM_RESET);
    end
    $display("t_sensor_regs done");
  endtask
  task automatic t_region_zero();
    role = ROLE_IDENTICAL;
    attached = 4'h3;
    // identical role: one value for every attached sensor, others keep reset
    echo(s_addr(0, OFS_ALARM_HIGH), 16'h04b0);
    for (int s = 0; s < NUM_SENSORS; s++)
      check(params[s].alarm_high, s < 3 ? 16'h04b0 : 16'h0000);
    $display("t_region_zero done");
  endtask
  task automatic t_role_test();
    role = ROLE_SINGLE;
    refuse(s_addr(0, OFS_SELF_TEST), CODE_ENGAGE, 1'b1, EXC_BAD_ROLE);
    role = ROLE_UNIQUE;
    attached = 4'h1;
    refuse(s_addr(0, OFS_ZONE), 16'h0007, 1'b1, EXC_BAD_ROLE);
    check(st_run, '0);
    attached = 4'h3;
    echo(s_addr(0, OFS_ZONE), 16'h0007);
    check(params[2].zone, 16'h0007);
    echo(s_addr(1, OFS_SELF_TEST), CODE_ENGAGE);
    check(st_run, 8'h01);
    echo(s_addr(1, OFS_SELF_TEST), CODE_STOP);
    check(st_run, 8'h00);
    $display("t_role_test done");
  endtask
  task automatic t_refusals();
    refuse(DIAG_FORCE_OUTPUTS, 16'h0003, 1'b0, EXC_NO_KEY);
    check({relay, led_swap}, 5'h00);
    refuse(16'h0b5e, 16'h0001, 1'b1, EXC_ILLEGAL_ADDR);
    refuse(16'h0b69, 16'h0001, 1'b1, EXC_ILLEGAL_ADDR);
    refuse(s_addr(4, OFS_ALARM_LOW), 16'h1, 1'b1, EXC_ILLEGAL_ADDR);
    quiet(1'b1, s_addr(1, OFS_ALARM_LOW), 16'h0055);
    ce = 1'b0;
    quiet(1'b0, s_addr(1, OFS_ALARM_LOW), 16'h0055);
    ce = 1'b1;
    check(params[0].alarm_low, PARAM_RESET);
    $display("t_refusals done");
  endtask
  task automatic t_clock();
    for (int i = 0; i < 6; i++) begin
      echo(CLOCK_MONTH_PENDING + 16'(i), 16'h0010 + 16'(i));
      check(clk_pending[95-16*i -: 16], 16'h0010 + 16'(i));
    end
    echo(CLOCK_COMMIT, CODE_ENGAGE);
    check({clk_load, clk_pend}, 2'b11);
    @(posedge core_clk_in);
    #1;
    check({clk_load, clk_pend}, 2'b01);
    echo(CLOCK_COMMIT, CODE_STOP);
    check(clk_pend, 1'b0);
    $display("t_clock done");
  endtask
  task automatic t_force();
    echo(DIAG_FORCE_OUTPUTS, 16'h001f);
    check({relay, led_swap}, 5'h1f);
    repeat (HOLD - 5) @(posedge core_clk_in);
    echo(DIAG_FORCE_OUTPUTS, 16'h0005);
    repeat (HOLD - 5) @(negedge core_clk_in);
    check({relay, led_swap}, 5'h0a);
    repeat (10) @(negedge core_clk_in);
    check({relay, led_swap}, 5'h00);
    $display("t_force done");
  endtask
  task automatic t_listen();
    quiet(1'b1, LISTEN_ONLY_ENGAGE, CODE_ENGAGE);
    check(listen, 1'b1);
    quiet(1'b0, s_addr(1, OFS_ALARM_LOW), 16'h0077);
    quiet(1'b0, DIAG_FORCE_OUTPUTS, 16'h000f);
    check({params[0].alarm_low, relay}, '0);
    echo(LISTEN_ONLY_RESTORE, CODE_ENGAGE);
    check(listen, 1'b0);
    quiet(1'b0, LISTEN_ONLY_ENGAGE, CODE_ENGAGE);
    quiet(1'b1, LISTEN_ONLY_RESTORE, CODE_ENGAGE);
    check(listen, 1'b0);
    echo(s_addr(1, OFS_ALARM_LOW), 16'h0033);
    check(params[0].alarm_low, 16'h0033);
    $display("t_listen done");
  endtask
  // ---------------------------------------------------------------
  // main sequence and hang guard
  // ---------------------------------------------------------------
  initial begin
    repeat (5) @(posedge core_clk_in);
    #1;
    reset_in = 1'b0;
    t_sensor_regs();
    t_region_zero();
    t_role_test();
    t_refusals();
    t_clock();
    t_force();
    t_listen();
    test_done();
  end
  initial begin
    #200000;
    bad_count++;
    test_done();
  end
endmodule // tb
